/* spc_pkg.sv */
/*
  Constants for the secondary timing path configuration register:
  field positions, reset value, PLL mode codes and analogue PLL rates.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package spc_pkg;
  localparam int          SPC_REG_W        = 8;
  localparam logic [7:0]  SPC_REG_RESET    = 8'h00;
  localparam logic [7:0]  SPC_REG_MASK     = 8'h77;
  localparam int          SPC_MODE_LSB     = 0;
  localparam int          SPC_MODE_MSB     = 2;
  localparam int          SPC_BITS_STD_BIT = 4;
  localparam int          SPC_DUTY_BIT     = 5;
  localparam int          SPC_AUTOSQ_BIT   = 6;
  localparam int          SPC_FREQ_W       = 20;

  typedef enum logic [2:0] {
    SPC_MODE_SQUELCH = 3'b000,
    SPC_MODE_OCN     = 3'b001,
    SPC_MODE_12E1    = 3'b010,
    SPC_MODE_16E1    = 3'b011,
    SPC_MODE_24DS1   = 3'b100,
    SPC_MODE_16DS1   = 3'b101,
    SPC_MODE_E3      = 3'b110,
    SPC_MODE_DS3     = 3'b111
  } spc_mode_e;

  // Pre-divider rates of the analogue multiplier PLL, in kHz
  localparam logic [19:0] SPC_KHZ_OFF   = 20'h00000;
  localparam logic [19:0] SPC_KHZ_12E1  = 20'd98304;
  localparam logic [19:0] SPC_KHZ_16E1  = 20'd131072;
  localparam logic [19:0] SPC_KHZ_24DS1 = 20'd148224;
  localparam logic [19:0] SPC_KHZ_16DS1 = 20'd98816;
  localparam logic [19:0] SPC_KHZ_E3    = 20'd274944;
  localparam logic [19:0] SPC_KHZ_DS3   = 20'd178944;
  localparam logic [19:0] SPC_KHZ_OCN   = 20'd77760;
endpackage
`default_nettype wire

/* spc_secondary_pll_cfg.sv */
/*
  Secondary timing path configuration register and the control levels
  derived from it: mode decode, analogue PLL rate, duty select, squelch.
  Assumes the microprocessor port decodes this register's address into
  write and read strobes on ref_clk, and that the failure, enable and
  primary-feed inputs come from logic on ref_clk.
*/
// Operation
// - Eight-bit read/write register, resets to zero
// - Decode three-bit mode into PLL modes
// - Fixed analogue PLL rate per mode
// - General output rates derive from that rate
// - Primary-path bit feeds analogue PLL from primary
// - Duty bit picks 50:50 or 5:8
`timescale 1ns/1ps
`default_nettype none
module spc_secondary_pll_cfg
  import spc_pkg::*;
#(
  parameter logic [SPC_FREQ_W-1:0] OCN_ANALOGUE_MULTIPLIER_PLL_KHZ = SPC_KHZ_OCN
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // Register port
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic [SPC_REG_W-1:0]  reg_wdata,
  output logic      [SPC_REG_W-1:0]  reg_rdata,
  // Surrounding state
  input  wire logic                  primary_feed_select,
  input  wire logic                  secondary_inputs_failed,
  input  wire logic                  composite_out_enable,
  input  wire logic                  bits_out_enable,
  // Secondary path control
  output spc_mode_e                  secondary_pll_mode,
  output logic                       secondary_pll_squelched,
  output logic                       secondary_ocn_rate,
  output logic                       analogue_multiplier_pll_from_primary,
  output logic                       analogue_multiplier_pll_free_run,
  output logic      [SPC_FREQ_W-1:0] analogue_multiplier_pll_pre_div_khz,
  output logic                       composite_duty_5to8,
  output logic                       bits_rate_standard_select,
  output logic                       composite_out_active,
  output logic                       bits_out_active
);

  function automatic logic [SPC_FREQ_W-1:0] mode_khz(input spc_mode_e m);
    case (m)
      SPC_MODE_OCN:   mode_khz = OCN_ANALOGUE_MULTIPLIER_PLL_KHZ;
      SPC_MODE_12E1:  mode_khz = SPC_KHZ_12E1;
      SPC_MODE_16E1:  mode_khz = SPC_KHZ_16E1;
      SPC_MODE_24DS1: mode_khz = SPC_KHZ_24DS1;
      SPC_MODE_16DS1: mode_khz = SPC_KHZ_16DS1;
      SPC_MODE_E3:    mode_khz = SPC_KHZ_E3;
      SPC_MODE_DS3:   mode_khz = SPC_KHZ_DS3;
      default:        mode_khz = SPC_KHZ_OFF;
    endcase
  endfunction

  logic [SPC_REG_W-1:0]  cfg_q,    cfg_d;
  logic [SPC_REG_W-1:0]  rdata_q,  rdata_d;
  spc_mode_e             mode_q,   mode_d;
  logic                  sq_q,     sq_d;
  logic                  ocn_q,    ocn_d;
  logic                  prim_q,   prim_d;
  logic                  free_q,   free_d;
  logic [SPC_FREQ_W-1:0] khz_q,    khz_d;
  logic                  duty_q,   duty_d;
  logic                  std_q,    std_d;
  logic                  comp_q,   comp_d;
  logic                  bits_q,   bits_d;
  spc_mode_e             cfg_mode;
  logic                  squelch_now;

  always_comb begin
    cfg_d   = reg_wr_en ? (reg_wdata & SPC_REG_MASK) : cfg_q;
    rdata_d = reg_rd_en ? cfg_q : rdata_q;
    cfg_mode = spc_mode_e'(cfg_q[SPC_MODE_MSB:SPC_MODE_LSB]);
    mode_d   = cfg_mode;
    sq_d     = (cfg_mode == SPC_MODE_SQUELCH);
    ocn_d    = (cfg_mode == SPC_MODE_OCN);
    prim_d = primary_feed_select;
    // Squelched input lets the analogue PLL free-run unless fed from primary
    free_d = sq_d && !primary_feed_select;
    // Pre-divider rate shared by general outputs
    khz_d = primary_feed_select ? khz_q : mode_khz(cfg_mode);
    if (free_d) begin
      khz_d = SPC_KHZ_OFF;
    end
    duty_d = cfg_q[SPC_DUTY_BIT];
    std_d  = cfg_q[SPC_BITS_STD_BIT];
    // Automatic squelch of composite and BITS
    squelch_now = cfg_q[SPC_AUTOSQ_BIT] && secondary_inputs_failed;
    comp_d = composite_out_enable && !squelch_now;
    bits_d = bits_out_enable && !squelch_now;
  end

  // Primary-fed rate is held, since the primary register owns that rate
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_q   <= SPC_REG_RESET;
      rdata_q <= SPC_REG_RESET;
      mode_q  <= SPC_MODE_SQUELCH;
      sq_q    <= 1'b1;
      ocn_q   <= 1'b0;
      prim_q  <= 1'b0;
      free_q  <= 1'b1;
      khz_q   <= SPC_KHZ_OFF;
      duty_q  <= 1'b0;
      std_q   <= 1'b0;
      comp_q  <= 1'b0;
      bits_q  <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
      mode_q  <= mode_d;
      sq_q    <= sq_d;
      ocn_q   <= ocn_d;
      prim_q  <= prim_d;
      free_q  <= free_d;
      khz_q   <= khz_d;
      duty_q  <= duty_d;
      std_q   <= std_d;
      comp_q  <= comp_d;
      bits_q  <= bits_d;
    end
  end

  assign reg_rdata                 = rdata_q;
  assign secondary_pll_mode        = mode_q;
  assign secondary_pll_squelched   = sq_q;
  assign secondary_ocn_rate        = ocn_q;
  assign analogue_multiplier_pll_from_primary         = prim_q;
  assign analogue_multiplier_pll_free_run             = free_q;
  assign analogue_multiplier_pll_pre_div_khz          = khz_q;
  assign composite_duty_5to8       = duty_q;
  assign bits_rate_standard_select = std_q;
  assign composite_out_active      = comp_q;
  assign bits_out_active           = bits_q;

  reg_write_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_wr_en ##1 (!reg_wr_en && reg_rd_en) |=> reg_rdata == ($past(reg_wdata, 2) & SPC_REG_MASK))
    else $error("Readback differs from written value");

  reset_zero_a: assert property (@(posedge ref_clk)
    !resetn |=> cfg_q == SPC_REG_RESET && reg_rdata == SPC_REG_RESET)
    else $error("Register not zero after reset");

  mode_decode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    secondary_pll_squelched == (secondary_pll_mode == SPC_MODE_SQUELCH)
    && secondary_ocn_rate == (secondary_pll_mode == SPC_MODE_OCN))
    else $error("Mode decode flags inconsistent");

  mode_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_wr_en ##1 !reg_wr_en |=> secondary_pll_mode == spc_mode_e'($past(reg_wdata[SPC_MODE_MSB:SPC_MODE_LSB], 2)))
    else $error("Mode output does not follow written field");

  e3_rate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg_q[SPC_MODE_MSB:SPC_MODE_LSB] == SPC_MODE_E3 && !primary_feed_select) |=> analogue_multiplier_pll_pre_div_khz == SPC_KHZ_E3)
    else $error("E3 mode rate wrong");

  rate_table_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !primary_feed_select |=> analogue_multiplier_pll_pre_div_khz == mode_khz(spc_mode_e'($past(cfg_q[SPC_MODE_MSB:SPC_MODE_LSB]))))
    else $error("Pre-divider rate does not match mode");

  primary_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (primary_feed_select && $past(primary_feed_select)) |=> $stable(analogue_multiplier_pll_pre_div_khz) && analogue_multiplier_pll_from_primary
    && !analogue_multiplier_pll_free_run)
    else $error("Primary feed does not hold analogue PLL");

  duty_sel_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_wr_en ##1 !reg_wr_en |=> composite_duty_5to8 == $past(reg_wdata[SPC_DUTY_BIT], 2))
    else $error("Duty select not applied");

  auto_squelch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg_q[SPC_AUTOSQ_BIT] && secondary_inputs_failed) |=> !composite_out_active && !bits_out_active)
    else $error("Outputs not squelched on failure");

  no_squelch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cfg_q[SPC_AUTOSQ_BIT] |=> composite_out_active == $past(composite_out_enable)
    && bits_out_active == $past(bits_out_enable))
    else $error("Outputs do not follow enables");

  unused_bits_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (reg_rdata & ~SPC_REG_MASK) == '0)
    else $error("Unused register bits read as one");

  // Readback holds between reads, so software may pick it up late
  rdata_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("Read data changed without a read");

  bits_std_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_wr_en ##1 !reg_wr_en |=> bits_rate_standard_select == $past(reg_wdata[SPC_BITS_STD_BIT], 2))
    else $error("BITS rate select not stored");

  free_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    analogue_multiplier_pll_free_run |-> analogue_multiplier_pll_pre_div_khz == SPC_KHZ_OFF && !analogue_multiplier_pll_from_primary)
    else $error("Free-running analogue PLL shows a rate");

  ocn_rate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (secondary_ocn_rate && !analogue_multiplier_pll_from_primary) |-> analogue_multiplier_pll_pre_div_khz == OCN_ANALOGUE_MULTIPLIER_PLL_KHZ)
    else $error("OC-N mode rate wrong");

  prim_copy_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    primary_feed_select |=> analogue_multiplier_pll_from_primary)
    else $error("Primary feed not applied");

  ds3_mode_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    analogue_multiplier_pll_pre_div_khz == SPC_KHZ_DS3);
  squelch_hit_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    composite_out_enable && secondary_inputs_failed && cfg_q[SPC_AUTOSQ_BIT] ##1 !composite_out_active);
  primary_feed_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    analogue_multiplier_pll_from_primary && secondary_pll_squelched);
  same_edge_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    reg_wr_en && reg_rd_en);
  squelch_release_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    !composite_out_active ##1 composite_out_active);

endmodule
`default_nettype wire

/* tb.sv */
/*
  Self-checking bench for the secondary path configuration register.
  Assumes spc_pkg and spc_secondary_pll_cfg are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spc_pkg::*;
  typedef struct packed {
    logic [7:0]  w;
    logic [19:0] khz;
  } spc_row_s;
  logic                  ref_clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [7:0]            wdata = 8'h00;
  logic                  prim = 1'b0;
  logic                  fail = 1'b0;
  logic                  c_en = 1'b1;
  logic                  b_en = 1'b1;
  logic [7:0]            rdata;
  logic [7:0]            v;
  spc_mode_e             mode;
  logic                  sq, ocn, from_prim, free_run, duty, std, c_act, b_act;
  logic [SPC_FREQ_W-1:0] khz;
  int                    fails = 0;
  int                    n_tests = 0;
  spc_row_s              rows [8];
  always #2.5 ref_clk = ~ref_clk;
  spc_secondary_pll_cfg uut (.ref_clk(ref_clk), .resetn(resetn), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .primary_feed_select(prim), .secondary_inputs_failed(fail),
    .composite_out_enable(c_en), .bits_out_enable(b_en), .secondary_pll_mode(mode),
    .secondary_pll_squelched(sq), .secondary_ocn_rate(ocn), .analogue_multiplier_pll_from_primary(from_prim),
    .analogue_multiplier_pll_free_run(free_run), .analogue_multiplier_pll_pre_div_khz(khz), .composite_duty_5to8(duty),
    .bits_rate_standard_select(std), .composite_out_active(c_act), .bits_out_active(b_act));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Derived outputs settle one edge after the write edge
  task automatic wr_reg(input logic [7:0] d);
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(2);
  endtask
  task automatic rd_reg(output logic [7:0] d);
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    d = rdata;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    end_sim();
  end
  initial begin
    // Rows mix in the unused bits 7 and 3 so that dropping them is seen
    rows[0] = '{8'h88, SPC_KHZ_OFF};
    rows[1] = '{8'h61, SPC_KHZ_OCN};
    rows[2] = '{8'h12, SPC_KHZ_12E1};
    rows[3] = '{8'h23, SPC_KHZ_16E1};
    rows[4] = '{8'h44, SPC_KHZ_24DS1};
    rows[5] = '{8'hFD, SPC_KHZ_16DS1};
    rows[6] = '{8'h66, SPC_KHZ_E3};
    rows[7] = '{8'h37, SPC_KHZ_DS3};
    cyc(3);
    resetn = 1'b1;
    chk("rst_mode", {mode, sq, free_run, khz, duty, c_act, b_act}, 32'h01800000);
    rd_reg(v);
    chk("rst_read", v, SPC_REG_RESET);
    $display("reset test done");
    foreach (rows[i]) begin
      wr_reg(rows[i].w);
      rd_reg(v);
      chk("readback", v, rows[i].w & SPC_REG_MASK);
      chk("mode", mode, rows[i].w[2:0]);
      chk("squelch", {sq, ocn}, {rows[i].w[2:0] == 3'h0, rows[i].w[2:0] == 3'h1});
      chk("free_run", free_run, rows[i].w[2:0] == 3'h0);
      chk("khz", khz, rows[i].khz);
      chk("duty", duty, rows[i].w[5]);
      chk("std", std, rows[i].w[4]);
      chk("active", {c_act, b_act}, 2'h3);
    end
    $display("table test done");
    fail = 1'b1;
    cyc(2);
    chk("no_autosq", {c_act, b_act}, 2'h3);
    c_en = 1'b0;
    cyc(2);
    chk("own_enable", {c_act, b_act}, 2'h1);
    c_en = 1'b1;
    wr_reg(8'h46);
    chk("autosq_fail", {c_act, b_act}, 2'h0);
    fail = 1'b0;
    cyc(2);
    chk("autosq_ok", {c_act, b_act}, 2'h3);
    $display("squelch test done");
    prim = 1'b1;
    wr_reg(8'h00);
    chk("prim_feed", {from_prim, free_run}, 2'h2);
    chk("prim_khz", khz, SPC_KHZ_E3);
    prim = 1'b0;
    cyc(2);
    chk("prim_off", {from_prim, free_run, khz}, {2'h1, SPC_KHZ_OFF});
    $display("primary feed test done");
    wdata = 8'h55;
    wr = 1'b1;
    rd = 1'b1;
    cyc(1);
    chk("same_edge", rdata, 8'h00);
    wr = 1'b0;
    cyc(1);
    rd = 1'b0;
    chk("after_same", rdata, 8'h55);
    resetn = 1'b0;
    cyc(1);
    resetn = 1'b1;
    chk("rerst", {mode, sq, duty, rdata}, {3'h0, 1'h1, 1'h0, 8'h00});
    rd_reg(v);
    chk("rerst_read", v, SPC_REG_RESET);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
